// >>> hdl/eeprom_pkg.sv
// constants and types shared by the serial eeprom design
package eeprom_pkg;
  // array geometry
  localparam int unsigned ARRAY_BYTES = 2048;
  localparam int unsigned BYTE_ADDR_W = 11;
  localparam int unsigned ADDR_X8_BITS = 11;
  localparam int unsigned ADDR_X16_BITS = 10;
  localparam int unsigned WORD_W = 16;
  localparam int unsigned BYTE_W = 8;
  localparam logic [15:0] ERASED_WORD = 16'hffff;
  // instruction opcodes
  localparam logic [1:0] OP_MISC = 2'b00;
  localparam logic [1:0] OP_WRITE = 2'b01;
  localparam logic [1:0] OP_READ = 2'b10;
  localparam logic [1:0] OP_ERASE = 2'b11;
  // address prefixes of the misc opcode
  localparam logic [1:0] PFX_DISABLE = 2'b00;
  localparam logic [1:0] PFX_WRITE_ALL = 2'b01;
  localparam logic [1:0] PFX_ERASE_ALL = 2'b10;
  localparam logic [1:0] PFX_ENABLE = 2'b11;
  // self-timed write cycle, longest time rounds down
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned WRITE_TIME_MS = 10;
  localparam int unsigned WRITE_CYCLES = WRITE_TIME_MS * 1_000_000 / CLK_PERIOD_NS;
  // write request queue entry: all flag, org flag, address, data
  localparam int unsigned FIFO_DEPTH = 16;
  localparam int unsigned REQ_W = 29;
  localparam int unsigned REQ_ALL_BIT = 28;
  localparam int unsigned REQ_ORG_BIT = 27;
  localparam int unsigned REQ_ADDR_LSB = 16;
  localparam int unsigned REQ_ADDR_MSB = 26;
  localparam int unsigned REQ_DATA_MSB = 15;
  typedef enum {ST_IDLE, ST_OPCODE, ST_ADDR, ST_DATA, ST_READ, ST_DONE} ser_state_t;
  typedef enum {WR_IDLE, WR_FILL, WR_WAIT} wr_state_t;
endpackage

// >>> hdl/serial_eeprom.sv
// write request fifo and serial eeprom core
//
// Functional notes
// R1 - org high gives 1024 x16 words, org low gives 2048 x8 words
// R2 - floating org selects x16, except on low-voltage builds
// R3 - serial interface acts only while chip select is high
// R4 - after a read instruction the addressed word shifts out serially
// R5 - writes are self-timed and overwrite directly, no prior erase
// R6 - writes run only when program enable is set, else discarded
// R7 - after a write starts, data out shows ready/busy while selected
// R8 - every write cycle ends within the bounded write time
// R9 - start bit 1, two-bit opcode, then 11 or 10 address bits
// R10 - misc opcode prefixes 11 enable, 10 erase all, 01 write all
// R11 - misc opcode prefix 00 clears program enable
// R12 - serial data sampled on rising shift clock while selected
module sync_fifo #(
  parameter int unsigned WIDTH = 29,
  parameter int unsigned DEPTH = 16
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int unsigned PTR_W = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PTR_W-1:0] wr_ptr_q, rd_ptr_q;
  logic [PTR_W:0] count_q;
  logic push, pop;
  if (DEPTH < 2 || (1 << PTR_W) != DEPTH) begin
    $error("fifo depth must be a power of two");
  end
  assign in_ready_o = (count_q != (PTR_W+1)'(DEPTH));
  assign out_valid_o = (count_q != '0);
  assign out_data_o = mem_q[rd_ptr_q];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_q[wr_ptr_q] <= in_data_i;
    end
  end
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= wr_ptr_q + 1'b1;
      end
      if (pop) begin
        rd_ptr_q <= rd_ptr_q + 1'b1;
      end
      count_q <= count_q + (PTR_W+1)'(push) - (PTR_W+1)'(pop);
    end
  end
endmodule
module serial_eeprom #(
  parameter int unsigned WRITE_CYCLES = eeprom_pkg::WRITE_CYCLES,
  parameter bit LOW_VOLTAGE = 1'b0
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // serial link
  input wire logic chip_select_i,
  input wire logic shift_clock_in_i,
  input wire logic serial_data_in_i,
  output logic serial_data_out_o,
  output logic serial_data_out_oe_o,
  // organisation strap
  input wire logic organisation_select_i,
  input wire logic organisation_floating_i
);
  logic [7:0] mem_q [eeprom_pkg::ARRAY_BYTES];
  eeprom_pkg::ser_state_t state_q;
  eeprom_pkg::wr_state_t wr_q;
  logic sk_prev_q, rd_bit_q, prog_en_q, req_valid_q, status_armed_q, do_q, do_oe_q, wr_org_q;
  logic [1:0] op_q, prefix;
  logic [4:0] cnt_q, addr_len, data_len;
  logic [10:0] addr_q, wr_addr_q, addr_next, seq_addr;
  logic [15:0] data_q, rd_shift_q, wr_data_q, data_next, seq_word;
  logic [eeprom_pkg::REQ_W-1:0] req_q, fifo_data, new_req_data;
  logic [31:0] timer_q;
  logic fifo_ready, fifo_valid, fifo_pop, org_x16, sk_rise, last_addr, last_data, new_req, busy;
  if (WRITE_CYCLES < 1) begin
    $error("write cycle count must be at least one");
  end
  // R1 R2 org decode
  assign org_x16 = organisation_floating_i ? !LOW_VOLTAGE : organisation_select_i;
  assign addr_len = org_x16 ? 5'(eeprom_pkg::ADDR_X16_BITS) : 5'(eeprom_pkg::ADDR_X8_BITS);
  assign data_len = org_x16 ? 5'(eeprom_pkg::WORD_W) : 5'(eeprom_pkg::BYTE_W);
  // R3 R12 rising edge while selected
  assign sk_rise = chip_select_i && shift_clock_in_i && !sk_prev_q;
  assign addr_next = org_x16 ? {1'b0, addr_q[8:0], serial_data_in_i}
                             : {addr_q[9:0], serial_data_in_i};
  assign data_next = org_x16 ? {data_q[14:0], serial_data_in_i}
                             : {8'h00, data_q[6:0], serial_data_in_i};
  assign prefix = org_x16 ? addr_next[9:8] : addr_next[10:9];
  assign last_addr = sk_rise && state_q == eeprom_pkg::ST_ADDR && cnt_q == addr_len - 5'd1;
  assign last_data = sk_rise && state_q == eeprom_pkg::ST_DATA && cnt_q == data_len - 5'd1;
  // R5 R6 R10 write request building
  always_comb begin
    new_req = 1'b0;
    new_req_data = '0;
    new_req_data[eeprom_pkg::REQ_ORG_BIT] = org_x16;
    new_req_data[eeprom_pkg::REQ_ADDR_MSB:eeprom_pkg::REQ_ADDR_LSB] = addr_q;
    new_req_data[eeprom_pkg::REQ_DATA_MSB:0] = data_next;
    if (last_addr && op_q == eeprom_pkg::OP_ERASE) begin
      new_req = prog_en_q;
      new_req_data[eeprom_pkg::REQ_ADDR_MSB:eeprom_pkg::REQ_ADDR_LSB] = addr_next;
      new_req_data[eeprom_pkg::REQ_DATA_MSB:0] = eeprom_pkg::ERASED_WORD;
    end else if (last_addr && op_q == eeprom_pkg::OP_MISC
                 && prefix == eeprom_pkg::PFX_ERASE_ALL) begin
      new_req = prog_en_q;
      new_req_data[eeprom_pkg::REQ_ALL_BIT] = 1'b1;
      new_req_data[eeprom_pkg::REQ_DATA_MSB:0] = eeprom_pkg::ERASED_WORD;
    end else if (last_data) begin
      new_req = prog_en_q;
      new_req_data[eeprom_pkg::REQ_ALL_BIT] = (op_q == eeprom_pkg::OP_MISC);
    end
  end
  function automatic logic [15:0] fetch(input logic [10:0] a, input logic x16);
    logic [15:0] w;
    w = x16 ? {mem_q[{a[9:0], 1'b1}], mem_q[{a[9:0], 1'b0}]} : {mem_q[a], 8'h00};
    return w;
  endfunction
  assign seq_addr = org_x16 ? {1'b0, addr_q[9:0] + 10'd1} : addr_q + 11'd1;
  always_comb begin
    seq_word = fetch(seq_addr, org_x16);
  end
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sk_prev_q <= 1'b0;
    end else begin
      sk_prev_q <= shift_clock_in_i;
    end
  end
  // R3 R9 R12 instruction shifter
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_q <= eeprom_pkg::ST_IDLE;
      op_q <= '0;
      addr_q <= '0;
      data_q <= '0;
      cnt_q <= '0;
      rd_shift_q <= '0;
      rd_bit_q <= 1'b0;
    end else if (!chip_select_i) begin
      state_q <= eeprom_pkg::ST_IDLE;
      cnt_q <= '0;
    end else if (sk_rise) begin
      unique case (state_q)
        eeprom_pkg::ST_IDLE: begin
          // start bit, held off while a request waits for the queue
          if (serial_data_in_i && !req_valid_q) begin
            state_q <= eeprom_pkg::ST_OPCODE;
            cnt_q <= '0;
          end
        end
        eeprom_pkg::ST_OPCODE: begin
          op_q <= {op_q[0], serial_data_in_i};
          cnt_q <= cnt_q + 5'd1;
          if (cnt_q == 5'd1) begin
            state_q <= eeprom_pkg::ST_ADDR;
            cnt_q <= '0;
          end
        end
        eeprom_pkg::ST_ADDR: begin
          addr_q <= addr_next;
          cnt_q <= cnt_q + 5'd1;
          if (last_addr) begin
            cnt_q <= '0;
            if (op_q == eeprom_pkg::OP_READ) begin
              // R4 dummy zero then stored word
              state_q <= eeprom_pkg::ST_READ;
              rd_shift_q <= fetch(addr_next, org_x16);
              rd_bit_q <= 1'b0;
            end else if (op_q == eeprom_pkg::OP_WRITE || (op_q == eeprom_pkg::OP_MISC
                         && prefix == eeprom_pkg::PFX_WRITE_ALL)) begin
              state_q <= eeprom_pkg::ST_DATA;
            end else begin
              state_q <= eeprom_pkg::ST_DONE;
            end
          end
        end
        eeprom_pkg::ST_DATA: begin
          data_q <= data_next;
          cnt_q <= cnt_q + 5'd1;
          if (last_data) begin
            state_q <= eeprom_pkg::ST_DONE;
          end
        end
        eeprom_pkg::ST_READ: begin
          // R4 sequential read rolls into the next word
          if (cnt_q == data_len) begin
            addr_q <= seq_addr;
            rd_bit_q <= seq_word[15];
            rd_shift_q <= {seq_word[14:0], 1'b0};
            cnt_q <= 5'd1;
          end else begin
            rd_bit_q <= rd_shift_q[15];
            rd_shift_q <= {rd_shift_q[14:0], 1'b0};
            cnt_q <= cnt_q + 5'd1;
          end
        end
        eeprom_pkg::ST_DONE: begin
          cnt_q <= cnt_q;
        end
      endcase
    end
  end
  // R10 R11 program enable state
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      prog_en_q <= 1'b0;
    end else if (last_addr && op_q == eeprom_pkg::OP_MISC) begin
      if (prefix == eeprom_pkg::PFX_ENABLE) begin
        prog_en_q <= 1'b1;
      end else if (prefix == eeprom_pkg::PFX_DISABLE) begin
        prog_en_q <= 1'b0;
      end
    end
  end
  // R6 accepted requests wait here for queue space
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      req_valid_q <= 1'b0;
      req_q <= '0;
    end else if (new_req) begin
      req_valid_q <= 1'b1;
      req_q <= new_req_data;
    end else if (fifo_ready) begin
      req_valid_q <= 1'b0;
    end
  end
  sync_fifo #(
    .WIDTH(eeprom_pkg::REQ_W),
    .DEPTH(eeprom_pkg::FIFO_DEPTH)
  ) u_req_fifo (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .in_valid_i(req_valid_q),
    .in_ready_o(fifo_ready),
    .in_data_i(req_q),
    .out_valid_o(fifo_valid),
    .out_ready_i(fifo_pop),
    .out_data_o(fifo_data)
  );
  assign fifo_pop = (wr_q == eeprom_pkg::WR_IDLE);
  // R5 R8 self-timed write engine
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wr_q <= eeprom_pkg::WR_IDLE;
      wr_addr_q <= '0;
      wr_data_q <= '0;
      wr_org_q <= 1'b0;
      timer_q <= '0;
    end else begin
      unique case (wr_q)
        eeprom_pkg::WR_IDLE: begin
          timer_q <= '0;
          if (fifo_valid) begin
            wr_data_q <= fifo_data[eeprom_pkg::REQ_DATA_MSB:0];
            wr_org_q <= fifo_data[eeprom_pkg::REQ_ORG_BIT];
            if (fifo_data[eeprom_pkg::REQ_ALL_BIT]) begin
              wr_q <= eeprom_pkg::WR_FILL;
              wr_addr_q <= '0;
            end else begin
              wr_q <= eeprom_pkg::WR_WAIT;
              wr_addr_q <= fifo_data[eeprom_pkg::REQ_ADDR_MSB:eeprom_pkg::REQ_ADDR_LSB];
            end
          end
        end
        eeprom_pkg::WR_FILL: begin
          timer_q <= timer_q + 32'd1;
          wr_addr_q <= wr_addr_q + 11'd1;
          if (wr_addr_q == 11'(eeprom_pkg::ARRAY_BYTES - 1)) begin
            wr_q <= eeprom_pkg::WR_WAIT;
          end
        end
        eeprom_pkg::WR_WAIT: begin
          timer_q <= timer_q + 32'd1;
          if (timer_q >= WRITE_CYCLES - 1) begin
            wr_q <= eeprom_pkg::WR_IDLE;
          end
        end
      endcase
    end
  end
  // R5 direct overwrite of the array
  always_ff @(posedge clk_i) begin
    if (wr_q == eeprom_pkg::WR_IDLE && fifo_valid
        && !fifo_data[eeprom_pkg::REQ_ALL_BIT]) begin
      if (fifo_data[eeprom_pkg::REQ_ORG_BIT]) begin
        mem_q[{fifo_data[eeprom_pkg::REQ_ADDR_LSB+9:eeprom_pkg::REQ_ADDR_LSB], 1'b1}]
          <= fifo_data[15:8];
        mem_q[{fifo_data[eeprom_pkg::REQ_ADDR_LSB+9:eeprom_pkg::REQ_ADDR_LSB], 1'b0}]
          <= fifo_data[7:0];
      end else begin
        mem_q[fifo_data[eeprom_pkg::REQ_ADDR_MSB:eeprom_pkg::REQ_ADDR_LSB]] <= fifo_data[7:0];
      end
    end else if (wr_q == eeprom_pkg::WR_FILL) begin
      mem_q[wr_addr_q] <= (wr_org_q && wr_addr_q[0]) ? wr_data_q[15:8] : wr_data_q[7:0];
    end
  end
  assign busy = req_valid_q || fifo_valid || wr_q != eeprom_pkg::WR_IDLE;
  // R7 ready/busy status arming
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      status_armed_q <= 1'b0;
    end else if (new_req) begin
      status_armed_q <= 1'b1;
    end else if (!busy && (!chip_select_i || state_q != eeprom_pkg::ST_IDLE)) begin
      status_armed_q <= 1'b0;
    end
  end
  // R4 R7 data out driver
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      do_q <= 1'b0;
      do_oe_q <= 1'b0;
    end else begin
      do_oe_q <= chip_select_i && (state_q == eeprom_pkg::ST_READ
                 || (state_q == eeprom_pkg::ST_IDLE && status_armed_q));
      do_q <= (state_q == eeprom_pkg::ST_READ) ? rd_bit_q : !busy;
    end
  end
  assign serial_data_out_o = do_q;
  assign serial_data_out_oe_o = do_oe_q;
endmodule

// >>> tb/eeprom_host.sv
// host model driving the three-wire link
module eeprom_host (
  // clock
  input wire logic clk_i,
  // link outputs
  output logic chip_select_o,
  output logic shift_clock_o,
  output logic serial_data_o,
  // link inputs
  input wire logic serial_data_out_i,
  input wire logic serial_data_out_oe_i
);
  timeunit 1ns;
  timeprecision 1ps;
  logic last_q = 1'b0;
  logic line;
  // released pin shows the inverse of its last level
  always @(posedge clk_i) begin
    if (serial_data_out_oe_i)
      last_q <= serial_data_out_i;
  end
  assign line = serial_data_out_oe_i ? serial_data_out_i : ~last_q;
  initial begin
    chip_select_o = 1'b0;
    shift_clock_o = 1'b0;
    serial_data_o = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  // data set while shift clock low
  task automatic shift(input logic b, output logic r);
    shift_clock_o = 1'b0;
    serial_data_o = b;
    tick(2 + $urandom % 3);
    shift_clock_o = 1'b1;
    tick(3);
    r = line;
  endtask
  task automatic frame(input logic [31:0] v, input int n, output logic [15:0] got);
    logic r;
    chip_select_o = 1'b1;
    tick(1);
    for (int i = n - 1; i >= 0; i--) begin
      shift(v[i], r);
      got = {got[14:0], r};
    end
    shift_clock_o = 1'b0;
    tick(1);
    chip_select_o = 1'b0;
    serial_data_o = ~serial_data_o;
    tick(3);
  endtask
  // poll ready/busy, allowing the full write time
  task automatic status(output logic busy, output logic ready);
    chip_select_o = 1'b1;
    tick(3);
    busy = line;
    for (int i = 0; i < 60000 && line !== 1'b1; i++)
      tick(1);
    ready = line;
    chip_select_o = 1'b0;
    tick(3);
  endtask
  task automatic noise(input int n);
    repeat (n) begin
      shift_clock_o = ~shift_clock_o;
      serial_data_o = 1'($urandom);
      tick(2);
    end
    shift_clock_o = 1'b0;
    tick(1);
  endtask
endmodule

// >>> tb/serial_eeprom_properties.sv
// port checker for the serial eeprom
module serial_eeprom_checker #(
  parameter int unsigned WRITE_CYCLES = 3000
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // serial link
  input wire logic chip_select_i,
  input wire logic shift_clock_in_i,
  input wire logic serial_data_in_i,
  input wire logic serial_data_out_o,
  input wire logic serial_data_out_oe_o,
  // organisation strap
  input wire logic organisation_select_i,
  input wire logic organisation_floating_i
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned BUSY_MAX = 17 * WRITE_CYCLES + 64;
  logic sk_q;
  logic [4:0] rise_q;
  logic [31:0] busy_q;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_b_i);
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sk_q <= 1'b0;
      rise_q <= 5'h00;
    end else begin
      sk_q <= shift_clock_in_i;
      if (!chip_select_i)
        rise_q <= 5'h00;
      else if (shift_clock_in_i && !sk_q && rise_q != 5'h1f)
        rise_q <= rise_q + 5'h01;
    end
  end
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i)
      busy_q <= 32'h0000_0000;
    else if (serial_data_out_oe_o && !serial_data_out_o)
      busy_q <= busy_q + 32'h0000_0001;
    else
      busy_q <= 32'h0000_0000;
  end
  a_reset_quiet: assert property (disable iff (1'b0) !rst_b_i [*2] |->
    !serial_data_out_oe_o && !serial_data_out_o) else $error("outputs active in reset");
  a_oe_needs_select: assert property (serial_data_out_oe_o |-> $past(chip_select_i))
    else $error("output enabled without select");
  a_oe_drop_deselect: assert property ($fell(chip_select_i) |=> !serial_data_out_oe_o)
    else $error("output enable late after deselect");
  a_oe_after_address: assert property ($rose(serial_data_out_oe_o) |->
    rise_q == 5'h00 || rise_q >= 5'h0d) else $error("output enabled mid instruction");
  a_ready_holds: assert property ((chip_select_i && !shift_clock_in_i) [*3] ##0
    (serial_data_out_oe_o && serial_data_out_o) ##1 (chip_select_i && !shift_clock_in_i)
    |-> serial_data_out_o) else $error("ready status fell back");
  a_oe_held_selected: assert property ((chip_select_i && !shift_clock_in_i) [*3] ##0
    serial_data_out_oe_o ##1 chip_select_i |-> serial_data_out_oe_o)
    else $error("output enable dropped while selected");
  a_busy_bounded: assert property (busy_q <= BUSY_MAX) else $error("busy too long");
  a_idle_deselect: assert property (!chip_select_i [*3] |-> !serial_data_out_oe_o)
    else $error("output enabled while deselected");
  cover property ($rose(serial_data_out_oe_o) && rise_q >= 5'h0d);
  cover property (serial_data_out_oe_o && serial_data_out_o && rise_q == 5'h00);
  cover property (busy_q == 32'h0000_0064);
endmodule

bind serial_eeprom serial_eeprom_checker #(.WRITE_CYCLES(WRITE_CYCLES)) chk (
  .clk_i, .rst_b_i, .chip_select_i, .shift_clock_in_i, .serial_data_in_i,
  .serial_data_out_o, .serial_data_out_oe_o, .organisation_select_i,
  .organisation_floating_i);

// >>> tb/three_wire_serial_eeprom_tb.sv
// self-checking bench for the serial eeprom
module three_wire_serial_eeprom_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned WCYC = 3000;
  logic clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic cs, sk, di, dout, oe, b, r;
  logic organisation_select = 1'b0;
  logic flt = 1'b0;
  logic org16 = 1'b0;
  logic en = 1'b0;
  logic [7:0] mem [0:2047];
  logic [15:0] got, d;
  int a;
  int fail_count = 0;
  int check_count = 0;
  always #5 clk_i = ~clk_i;
  serial_eeprom #(.WRITE_CYCLES(WCYC)) uut (.clk_i(clk_i), .rst_b_i(rst_b_i),
    .chip_select_i(cs), .shift_clock_in_i(sk), .serial_data_in_i(di),
    .serial_data_out_o(dout), .serial_data_out_oe_o(oe),
    .organisation_select_i(organisation_select), .organisation_floating_i(flt));
  eeprom_host host (.clk_i(clk_i), .chip_select_o(cs), .shift_clock_o(sk),
    .serial_data_o(di), .serial_data_out_i(dout), .serial_data_out_oe_i(oe));
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk_data(input logic [15:0] g, input logic [15:0] e);
    check_count++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic chk_flag(input logic g, input logic e);
    chk_data({15'h0, g}, {15'h0, e});
  endtask
  task automatic instr(input logic [1:0] op, input int a, input logic [15:0] d, input int nd);
    int aw;
    logic [31:0] v;
    aw = org16 ? 10 : 11;
    v = {30'h0, op} | 32'h0000_0004;
    v = (v << aw) | (a & ((1 << aw) - 1));
    v = (v << nd) | (d & ((1 << nd) - 1));
    host.frame(v, 3 + aw + nd, got);
  endtask
  function automatic logic [15:0] exp_rd(input int a);
    return org16 ? {mem[2*a+1], mem[2*a]} : {8'h00, mem[a]};
  endfunction
  task automatic put(input int a, input logic [15:0] d);
    if (en && org16)
      {mem[2*a+1], mem[2*a]} = d;
    else if (en)
      mem[a] = d[7:0];
  endtask
  task automatic rd(input int a);
    instr(2'b10, a, 16'h0000, org16 ? 16 : 8);
    chk_data(org16 ? got : {8'h00, got[7:0]}, exp_rd(a));
  endtask
  task automatic wr(input logic [1:0] op, input int a, input logic [15:0] d, input int nd,
      input logic prog);
    instr(op, a, d, nd);
    if (op == 2'b01)
      put(a, d);
    if (op == 2'b11)
      put(a, 16'hffff);
    if (prog && en) begin
      host.status(b, r);
      chk_flag(b, 1'b0);
      chk_flag(r, 1'b1);
    end
  endtask
  task automatic misc(input logic [1:0] p, input logic [15:0] d);
    logic prog;
    prog = p[1] ^ p[0];
    wr(2'b00, int'(p) << (org16 ? 8 : 9), d, p == 2'b01 ? (org16 ? 16 : 8) : 0, prog);
    en = p == 2'b11 ? 1'b1 : (p == 2'b00 ? 1'b0 : en);
    for (int i = 0; i < 2048 && prog && en; i++)
      mem[i] = p[1] ? 8'hff : (org16 && i % 2 ? d[15:8] : d[7:0]);
  endtask
  initial begin
    void'($urandom(32'h0000_b612));
    repeat (8) @(posedge clk_i);
    #1 rst_b_i = 1'b1;
    repeat (2) @(posedge clk_i);
    #1;
    misc(2'b11, 16'h0000);
    misc(2'b10, 16'h0000);
    for (int i = 0; i < 3; i++)
      rd($urandom % 2048);
    for (int i = 0; i < 4; i++) begin
      a = $urandom % 2048;
      d = 16'($urandom);
      wr(2'b01, a, d, 8, 1'b1);
      rd(a);
    end
    instr(2'b10, a, 16'h0000, 16);
    chk_data(got, {mem[a], mem[(a + 1) % 2048]});
    organisation_select = 1'b1;
    org16 = 1'b1;
    a = $urandom % 1024;
    wr(2'b01, a, d, 16, 1'b1);
    rd(a);
    organisation_select = 1'b0;
    org16 = 1'b0;
    rd(2 * a);
    rd(2 * a + 1);
    organisation_select = 1'b1;
    org16 = 1'b1;
    wr(2'b11, a, 16'h0000, 0, 1'b1);
    rd(a);
    misc(2'b00, 16'h0000);
    wr(2'b01, a, ~d, 16, 1'b1);
    rd(a);
    host.noise(20);
    rd(a);
    organisation_select = 1'b0;
    flt = 1'b1;
    rd(a);
    misc(2'b11, 16'h0000);
    misc(2'b01, d);
    rd($urandom % 1024);
    wrap_up();
  end
  initial begin
    #1_000_000;
    fail_count++;
    wrap_up();
  end
endmodule
